// [hw/cpbc_pkg.sv]
// Purpose : shared constants and carriers of the code prefetch and branch cache
// Assumes : one 20 MHz clock, active-low asynchronous reset
// Notes   : the sizes, the PC, wait-state and ahead reset values and the machine cycle length of the block live here
package cpbc_pkg;

  // ==========================================================
  // sizes and reset values
  localparam int          QUEUE_BYTES  = 4;
  localparam int          CACHE_WAYS   = 4;
  localparam int          LINE_BYTES   = 4;
  localparam int          MCYCLE_CLKS  = 4;
  localparam int          FIFO_DEPTH   = 8;
  localparam logic [15:0] PC_RESET     = 16'h0000;
  localparam logic [2:0]  WS_RESET     = 3'h0;
  localparam logic [2:0]  AHEAD_RESET  = 3'h0;
  localparam logic [1:0]  MCYCLE_LAST  = 2'(MCYCLE_CLKS - 1);
  localparam logic [1:0]  LRU_OLDEST   = 2'(CACHE_WAYS - 1);

  // ==========================================================
  // carriers
  typedef struct packed {
    logic       prefetch_en;
    logic       separate_data_ws;
    logic [2:0] data_ws;
    logic [2:0] code_ws;
  } cpbc_bus_timing_t;

  typedef struct packed {
    logic        branch;
    logic [15:0] dest;
    logic        take;
    logic        take_two;
  } cpbc_exec_req_t;

  typedef struct packed {
    logic [2:0] count;
    logic [7:0] byte1;
    logic [7:0] byte0;
  } cpbc_instr_t;

  // one memory word reordered so the byte at the fetch address comes first
  typedef struct packed {
    logic       two;
    logic [7:0] second;
    logic [7:0] first;
  } cpbc_word_t;

endpackage : cpbc_pkg

// [hw/cpbc_prefetch.sv]
// Purpose : instruction fetch front end with prefetch queue and branch cache
// Assumes : program memory answers on the same clock; exec unit on the same clock
// Notes   : a word FIFO sits between the memory bus and the prefetch queue
//
// Functional notes
// RULE1: prefetch one word per idle bus period
// RULE2: fetching runs independent of execution timing
// RULE3: only fetch words whose bytes are used
// RULE4: at most four bytes held ahead
// RULE5: branch flushes queue, reloads from destination
// RULE6: four entries, destination compared in parallel
// RULE7: each entry holds four bytes at destination
// RULE8: hit moves four bytes in one transfer
// RULE9: queue and cache enabled after reset
// RULE10: firmware may disable prefetch and cache
// RULE11: configurable wait states per memory access
// RULE12: firmware sets four states at 40 MHz
// RULE13: firmware sets five states at 3.3 V
// RULE14: machine cycle four clocks, fetch hidden
// RULE15: data uses code wait states unless separate
// RULE16: classic cycle counts at one third clocks
// RULE17: two-byte instruction handed over in one cycle
// RULE18: sixteen-bit program counter drives fetching
// RULE19: reset clears program counter to zero
// RULE20: miss allocates least recently used entry
// RULE21: disabled means on-demand bytes, cache invalid
`timescale 1ns/1ps

// ==========================================================
// word FIFO with flush
module cpbc_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output      logic             in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output      logic             out_valid_o,
  input  wire logic             out_ready_i,
  output      logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("cpbc_fifo depth must be a power of two, at least 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             do_wr;
  logic             do_rd;

  assign in_ready_o  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_ptr != rd_ptr;
  assign out_data_o  = mem[rd_ptr[AW-1:0]];
  assign do_wr       = in_valid_i && in_ready_o && !flush_i;
  assign do_rd       = out_valid_o && out_ready_i && !flush_i;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr <= '0;
    end else if (flush_i) begin
      wr_ptr <= '0;
    end else if (do_wr) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_ptr <= '0;
    end else if (flush_i) begin
      rd_ptr <= '0;
    end else if (do_rd) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
endmodule : cpbc_fifo

// ==========================================================
// fetch front end
module cpbc_prefetch #(
  parameter int FIFO_DEPTH = cpbc_pkg::FIFO_DEPTH
) (
  input  wire logic                       clk_i,
  input  wire logic                       rstn_i,
  input  wire cpbc_pkg::cpbc_bus_timing_t bus_timing_control_reg_i,
  input  wire cpbc_pkg::cpbc_exec_req_t   exec_req_i,
  output      cpbc_pkg::cpbc_instr_t      instr_o,
  output      logic [15:0]                program_counter_o,
  output      logic                       mcycle_o,
  output      logic [2:0]                 data_wait_states_o,
  output      logic                       mem_rd_o,
  output      logic [15:0]                mem_addr_o,
  input  wire logic [15:0]                mem_rdata_i
);
  localparam int WW = $bits(cpbc_pkg::cpbc_word_t);

  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("cpbc_prefetch needs a FIFO of at least two words");
    end
  end

  typedef enum logic [0:0] {FS_IDLE, FS_WAIT} cpbc_fstate_t;

  // ==========================================================
  // state
  cpbc_fstate_t        fstate;
  logic [2:0]          ws_cnt;
  logic [15:0]         fetch_pc;
  logic                fetch_odd;
  logic                fetch_two;
  logic                discard;
  logic                push_valid;
  cpbc_pkg::cpbc_word_t push_word;
  logic [2:0]          ahead;
  logic [7:0]          q [cpbc_pkg::QUEUE_BYTES];
  logic [2:0]          q_cnt;
  logic [15:0]         tag    [cpbc_pkg::CACHE_WAYS];
  logic [7:0]          line   [cpbc_pkg::CACHE_WAYS][cpbc_pkg::LINE_BYTES];
  logic                valid  [cpbc_pkg::CACHE_WAYS];
  logic [1:0]          age    [cpbc_pkg::CACHE_WAYS];
  logic                fill_on;
  logic [1:0]          fill_way;
  logic [2:0]          fill_cnt;
  logic [1:0]          mc_cnt;

  // ==========================================================
  // combinational decode
  logic                 enable;
  logic                 branch;
  logic                 hit;
  logic [1:0]           hit_way;
  logic [1:0]           lru_way;
  logic [2:0]           take_n;
  logic [2:0]           issue_n;
  logic                 issue;
  logic                 done;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic                 fifo_out_ready;
  cpbc_pkg::cpbc_word_t fifo_out;
  logic [2:0]           word_n;
  logic [2:0]           after_pop;
  logic [2:0]           next_q_cnt;
  logic [7:0]           next_q [cpbc_pkg::QUEUE_BYTES];

  function automatic logic [2:0] byte_count(input logic two);
    byte_count = two ? 3'h2 : 3'h1;
  endfunction : byte_count

  // RULE9 no disabled state held from reset
  // RULE10 firmware enable bit
  assign enable = bus_timing_control_reg_i.prefetch_en;
  assign branch = exec_req_i.branch;
  assign done   = (fstate == FS_WAIT) && (ws_cnt == 3'h0);

  // RULE6 parallel tag compare
  always_comb begin
    hit     = 1'b0;
    hit_way = 2'h0;
    lru_way = 2'h0;
    for (int w = 0; w < cpbc_pkg::CACHE_WAYS; w++) begin
      if (enable && valid[w] && tag[w] == exec_req_i.dest) begin
        hit     = 1'b1;
        hit_way = 2'(w);
      end
      if (age[w] == cpbc_pkg::LRU_OLDEST) begin
        lru_way = 2'(w);
      end
    end
  end

  // refused take: more bytes than the queue holds, or a branch the same cycle
  assign take_n = (exec_req_i.take && !branch &&
                   byte_count(exec_req_i.take_two) <= q_cnt) ?
                  byte_count(exec_req_i.take_two) : 3'h0;

  // RULE3 odd or disabled fetch keeps one byte only
  assign issue_n = (enable && !fetch_pc[0]) ? 3'h2 : 3'h1;
  // RULE4 limit bytes ahead
  // RULE21 disabled fetches only when nothing is ahead
  // RULE1 fetch during idle bus
  assign issue = (fstate == FS_IDLE) && !branch && fifo_in_ready &&
                 (enable ? (ahead + issue_n <= 3'(cpbc_pkg::QUEUE_BYTES))
                         : (ahead == 3'h0));

  // RULE17 pop up to two bytes and refill in the same cycle
  assign word_n         = byte_count(fifo_out.two);
  assign after_pop      = q_cnt - take_n;
  assign fifo_out_ready = !branch && (after_pop + word_n <= 3'(cpbc_pkg::QUEUE_BYTES));

  always_comb begin
    next_q_cnt = after_pop;
    for (int i = 0; i < cpbc_pkg::QUEUE_BYTES; i++) begin
      next_q[i] = (3'(i) + take_n < 3'(cpbc_pkg::QUEUE_BYTES)) ? q[i + int'(take_n)] : 8'h00;
    end
    if (fifo_out_valid && fifo_out_ready) begin
      next_q[after_pop[1:0]] = fifo_out.first;
      if (fifo_out.two) begin
        next_q[2'(after_pop + 3'h1)] = fifo_out.second;
      end
      next_q_cnt = after_pop + word_n;
    end
  end

  // RULE2 memory words decouple through the FIFO
  cpbc_fifo #(
    .WIDTH (WW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .flush_i     (branch),
    .in_valid_i  (push_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (push_word),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out)
  );

  // ==========================================================
  // memory access sequencer
  // RULE11 wait states counted per access
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fstate     <= FS_IDLE;
      ws_cnt     <= cpbc_pkg::WS_RESET;
      mem_rd_o   <= 1'b0;
      mem_addr_o <= cpbc_pkg::PC_RESET;
      fetch_odd  <= 1'b0;
      fetch_two  <= 1'b0;
    end else if (issue) begin
      fstate     <= FS_WAIT;
      ws_cnt     <= bus_timing_control_reg_i.code_ws;
      mem_rd_o   <= 1'b1;
      mem_addr_o <= {fetch_pc[15:1], 1'b0};
      fetch_odd  <= fetch_pc[0];
      fetch_two  <= issue_n == 3'h2;
    end else if (done) begin
      fstate   <= FS_IDLE;
      mem_rd_o <= 1'b0;
    end else if (fstate == FS_WAIT) begin
      ws_cnt <= ws_cnt - 3'h1;
    end
  end

  // a bus access in flight cannot be cut short, so its word is dropped
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      discard <= 1'b0;
    end else if (branch && fstate == FS_WAIT && !done) begin
      discard <= 1'b1;
    end else if (done) begin
      discard <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      push_valid <= 1'b0;
      push_word  <= '0;
    end else begin
      push_valid       <= done && !discard && !branch;
      push_word.two    <= fetch_two;
      push_word.first  <= fetch_odd ? mem_rdata_i[15:8] : mem_rdata_i[7:0];
      push_word.second <= mem_rdata_i[15:8];
    end
  end

  // RULE18 fetch address counter
  // RULE5 reload from destination
  // RULE19 reset to zero
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fetch_pc <= cpbc_pkg::PC_RESET;
    end else if (branch) begin
      fetch_pc <= hit ? exec_req_i.dest + 16'(cpbc_pkg::LINE_BYTES) : exec_req_i.dest;
    end else if (issue) begin
      fetch_pc <= fetch_pc + 16'(issue_n);
    end
  end

  // bytes in queue, FIFO and in flight
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ahead <= cpbc_pkg::AHEAD_RESET;
    end else if (branch) begin
      ahead <= hit ? 3'(cpbc_pkg::LINE_BYTES) : 3'h0;
    end else begin
      ahead <= ahead + (issue ? issue_n : 3'h0) - take_n;
    end
  end

  // ==========================================================
  // prefetch queue
  // RULE5 flush and reload
  // RULE8 whole line in one transfer
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_cnt <= 3'h0;
      for (int i = 0; i < cpbc_pkg::QUEUE_BYTES; i++) begin
        q[i] <= 8'h00;
      end
    end else if (branch) begin
      q_cnt <= hit ? 3'(cpbc_pkg::LINE_BYTES) : 3'h0;
      for (int i = 0; i < cpbc_pkg::QUEUE_BYTES; i++) begin
        q[i] <= line[hit_way][i];
      end
    end else begin
      q_cnt <= next_q_cnt;
      q     <= next_q;
    end
  end

  // ==========================================================
  // branch cache
  // RULE7 line fill from queue arrivals
  // RULE20 miss allocates oldest way
  // RULE21 disabled invalidates all ways
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fill_on  <= 1'b0;
      fill_way <= 2'h0;
      fill_cnt <= 3'h0;
      for (int w = 0; w < cpbc_pkg::CACHE_WAYS; w++) begin
        valid[w] <= 1'b0;
        tag[w]   <= cpbc_pkg::PC_RESET;
        age[w]   <= 2'(w);
        for (int b = 0; b < cpbc_pkg::LINE_BYTES; b++) begin
          line[w][b] <= 8'h00;
        end
      end
    end else if (!enable) begin
      fill_on <= 1'b0;
      for (int w = 0; w < cpbc_pkg::CACHE_WAYS; w++) begin
        valid[w] <= 1'b0;
      end
    end else if (branch) begin
      for (int w = 0; w < cpbc_pkg::CACHE_WAYS; w++) begin
        if (age[w] < age[hit ? hit_way : lru_way]) begin
          age[w] <= age[w] + 2'h1;
        end
      end
      age[hit ? hit_way : lru_way] <= 2'h0;
      fill_on <= !hit;
      if (!hit) begin
        fill_way       <= lru_way;
        fill_cnt       <= 3'h0;
        tag[lru_way]   <= exec_req_i.dest;
        valid[lru_way] <= 1'b0;
      end
    end else if (fill_on && fifo_out_valid && fifo_out_ready) begin
      line[fill_way][fill_cnt[1:0]] <= fifo_out.first;
      if (fifo_out.two && fill_cnt < 3'(cpbc_pkg::LINE_BYTES - 1)) begin
        line[fill_way][2'(fill_cnt + 3'h1)] <= fifo_out.second;
      end
      if (fill_cnt + word_n >= 3'(cpbc_pkg::LINE_BYTES)) begin
        fill_on         <= 1'b0;
        valid[fill_way] <= 1'b1;
      end
      fill_cnt <= fill_cnt + word_n;
    end
  end

  // ==========================================================
  // execution side
  // RULE18 next instruction address
  // RULE19 reset vector at zero
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      program_counter_o <= cpbc_pkg::PC_RESET;
    end else if (branch) begin
      program_counter_o <= exec_req_i.dest;
    end else begin
      program_counter_o <= program_counter_o + 16'(take_n);
    end
  end

  // RULE17 head two bytes offered together
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      instr_o <= '0;
    end else if (branch) begin
      instr_o.count <= hit ? 3'(cpbc_pkg::LINE_BYTES) : 3'h0;
      instr_o.byte0 <= hit ? line[hit_way][0] : 8'h00;
      instr_o.byte1 <= hit ? line[hit_way][1] : 8'h00;
    end else begin
      instr_o.count <= next_q_cnt;
      instr_o.byte0 <= next_q[0];
      instr_o.byte1 <= next_q[1];
    end
  end

  // RULE14 four-clock machine cycle
  // RULE16 exec unit steps on this pulse
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mc_cnt   <= 2'h0;
      mcycle_o <= 1'b0;
    end else begin
      mc_cnt   <= mc_cnt + 2'h1;
      mcycle_o <= mc_cnt == cpbc_pkg::MCYCLE_LAST;
    end
  end

  // RULE15 data wait states follow code unless separate
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_wait_states_o <= cpbc_pkg::WS_RESET;
    end else begin
      data_wait_states_o <= bus_timing_control_reg_i.separate_data_ws ?
                            bus_timing_control_reg_i.data_ws :
                            bus_timing_control_reg_i.code_ws;
    end
  end
endmodule : cpbc_prefetch

// [sim/cpbc_mem_model.sv]
// Purpose : program memory seen by the fetch unit
// Assumes : contents are a fixed function of the byte address
// Notes   : released bus shows the inverse of its last value
`timescale 1ns/1ps
module cpbc_mem_model (
  input  wire logic        clk_i,
  input  wire logic        mem_rd_i,
  input  wire logic [15:0] mem_addr_i,
  output      logic [15:0] mem_rdata_o
);
  function automatic logic [7:0] code_at(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction : code_at

  initial mem_rdata_o = 16'h0000;

  // even byte in the low half
  always @(negedge clk_i) begin
    if (mem_rd_i) begin
      mem_rdata_o <= {code_at(mem_addr_i | 16'h0001), code_at(mem_addr_i & 16'hFFFE)};
    end else begin
      // no stale data once released
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule : cpbc_mem_model

// [sim/cpbc_prefetch_asserts.sv]
// Purpose : port-level checks of the fetch front end
// Assumes : wait-state fields only change while reset is held
// Notes   : bound into cpbc_prefetch after the module
`timescale 1ns/1ps
module cpbc_prefetch_asserts (
  input wire logic                       clk_i,
  input wire logic                       rstn_i,
  input wire cpbc_pkg::cpbc_bus_timing_t bus_timing_control_reg_i,
  input wire cpbc_pkg::cpbc_exec_req_t   exec_req_i,
  input wire cpbc_pkg::cpbc_instr_t      instr_o,
  input wire logic [15:0]                program_counter_o,
  input wire logic                       mcycle_o,
  input wire logic [2:0]                 data_wait_states_o,
  input wire logic                       mem_rd_o,
  input wire logic [15:0]                mem_addr_o,
  input wire logic [15:0]                mem_rdata_i
);
  logic [3:0] rd_len;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // ==========================================================
  // access length helper
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_len <= 4'h0;
    end else if (mem_rd_o) begin
      rd_len <= rd_len + 4'h1;
    end else begin
      rd_len <= 4'h0;
    end
  end

  // ==========================================================
  // checks
  addr_even_a : assert property (mem_rd_o |-> !mem_addr_o[0])
    else $error("fetch address not word aligned");
  access_len_a : assert property ($fell(mem_rd_o) |->
    rd_len == {1'b0, bus_timing_control_reg_i.code_ws} + 4'h1)
    else $error("access length differs from wait states");
  addr_hold_a : assert property (mem_rd_o && $past(mem_rd_o) |-> $stable(mem_addr_o))
    else $error("address moved during access");
  queue_max_a : assert property (instr_o.count <= 3'h4)
    else $error("queue holds more than four bytes");
  mcycle_period_a : assert property (mcycle_o |=> !mcycle_o [*3] ##1 mcycle_o)
    else $error("machine cycle not four clocks");
  mcycle_due_a : assert property (!mcycle_o [*4] |=> mcycle_o)
    else $error("machine cycle pulse missing");
  data_ws_a : assert property ($past(rstn_i) |-> data_wait_states_o ==
    $past(bus_timing_control_reg_i.separate_data_ws ? bus_timing_control_reg_i.data_ws
                                                    : bus_timing_control_reg_i.code_ws))
    else $error("data wait states wrong");
  reset_fetch_a : assert property ($rose(rstn_i) && bus_timing_control_reg_i.prefetch_en
    |-> program_counter_o == 16'h0000 ##1 (mem_rd_o && mem_addr_o == 16'h0000))
    else $error("first fetch not at zero");
  branch_pc_a : assert property (exec_req_i.branch |=>
    program_counter_o == $past(exec_req_i.dest))
    else $error("branch did not load counter");
endmodule : cpbc_prefetch_asserts

bind cpbc_prefetch cpbc_prefetch_asserts cpbc_prefetch_asserts_inst (
  .clk_i                    (clk_i),
  .rstn_i                   (rstn_i),
  .bus_timing_control_reg_i (bus_timing_control_reg_i),
  .exec_req_i               (exec_req_i),
  .instr_o                  (instr_o),
  .program_counter_o        (program_counter_o),
  .mcycle_o                 (mcycle_o),
  .data_wait_states_o       (data_wait_states_o),
  .mem_rd_o                 (mem_rd_o),
  .mem_addr_o               (mem_addr_o),
  .mem_rdata_i              (mem_rdata_i)
);

// [sim/tb_cpbc_prefetch.sv]
// Purpose : self-checking bench of the fetch front end
// Assumes : memory model answers every access
// Notes   : takes are noted in a queue and compared when consumed
`timescale 1ns/1ps
module tb_cpbc_prefetch;
  logic                       clk_i = 1'b0;
  logic                       rstn_i;
  cpbc_pkg::cpbc_bus_timing_t bus;
  cpbc_pkg::cpbc_exec_req_t   req;
  cpbc_pkg::cpbc_instr_t      instr;
  logic [15:0]                pc;
  logic [15:0]                mem_addr;
  logic [15:0]                mem_rdata;
  logic                       mem_rd;
  logic [32:0]                notes[$];
  logic [32:0]                note;
  logic [15:0]                exp_pc;
  logic [15:0]                d;
  logic                       bytes_ok;
  int                         fail_count = 0;
  int                         checks_done = 0;
  int                         cycles = 0;
  int                         seed = 32'h76c1419c;

  cpbc_prefetch #(.FIFO_DEPTH(8)) cpbc_prefetch_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .bus_timing_control_reg_i(bus), .exec_req_i(req),
    .instr_o(instr), .program_counter_o(pc), .mcycle_o(), .data_wait_states_o(),
    .mem_rd_o(mem_rd), .mem_addr_o(mem_addr), .mem_rdata_i(mem_rdata));
  cpbc_mem_model cpbc_mem_model_inst (
    .clk_i(clk_i), .mem_rd_i(mem_rd), .mem_addr_i(mem_addr), .mem_rdata_o(mem_rdata));

  always #25 clk_i = ~clk_i;

  function automatic logic [7:0] code_at(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction : code_at

  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("Error %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // ==========================================================
  // drivers
  task automatic do_reset();
    @(negedge clk_i);
    rstn_i = 1'b0;
    req = '0;
    repeat (6) @(negedge clk_i);
    rstn_i = 1'b1;
    exp_pc = 16'h0000;
    notes.delete();
  endtask : do_reset

  task automatic take_bytes(input logic two);
    logic [2:0] n;
    n = two ? 3'h2 : 3'h1;
    for (int i = 0; i < 300; i++) begin
      @(negedge clk_i);
      if (instr.count >= n) begin
        req = '{branch: 1'b0, dest: 16'h0000, take: 1'b1, take_two: two};
        notes.push_back({two, exp_pc, code_at(exp_pc + 16'h1), code_at(exp_pc)});
        exp_pc = exp_pc + 16'(n);
        return;
      end
      req.take = 1'b0;
    end
    chk(1'b0, "queue never filled");
  endtask : take_bytes

  task automatic branch_to(input logic [15:0] dest, input logic hit);
    @(negedge clk_i);
    req = '{branch: 1'b1, dest: dest, take: 1'b0, take_two: 1'b0};
    @(negedge clk_i);
    req.branch = 1'b0;
    exp_pc = dest;
    chk(pc === dest && instr.count === (hit ? 3'h4 : 3'h0), "branch refill");
  endtask : branch_to

  // ==========================================================
  // monitor of consumed bytes
  always @(posedge clk_i) begin
    if (rstn_i === 1'b1 && req.take && !req.branch &&
        instr.count >= (req.take_two ? 3'h2 : 3'h1)) begin
      if (notes.size() == 0) begin
        chk(1'b0, "take without note");
      end else begin
        note = notes.pop_front();
        bytes_ok = instr.byte0 === note[7:0] && (!note[32] || instr.byte1 === note[15:8]);
        chk(pc === note[31:16] && bytes_ok, "instruction bytes");
      end
    end
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      summarize();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    rstn_i = 1'b0;
    req = '0;
    bus = '{prefetch_en: 1'b1, separate_data_ws: 1'b0, data_ws: 3'h0, code_ws: 3'h4};
    for (int run = 0; run < 3; run++) begin
      // wait states only change under reset, an access in flight keeps its count
      @(negedge clk_i);
      rstn_i = 1'b0;
      bus.code_ws = (run == 0) ? 3'h4 : (run == 1) ? 3'h5 : 3'($random(seed));
      bus.data_ws = 3'($random(seed));
      bus.separate_data_ws = 1'($random(seed));
      bus.prefetch_en = 1'b1;
      do_reset();
      for (int i = 0; i < 30; i++) take_bytes(1'($random(seed)));
      // stall so the buffer fills, then drain
      repeat (40) @(negedge clk_i) req.take = 1'b0;
      for (int i = 0; i < 8; i++) take_bytes(1'b1);
      d = 16'($random(seed));
      for (int k = 0; k < 5; k++) begin
        branch_to(d + 16'(k * 256), 1'b0);
        take_bytes(1'b1);
        take_bytes(1'b1);
      end
      branch_to(d, 1'b0);
      take_bytes(1'b1);
      branch_to(d + 16'h0400, 1'b1);
      for (int i = 0; i < 4; i++) take_bytes(1'b0);
      @(negedge clk_i);
      bus.prefetch_en = 1'b0;
      req.take = 1'b0;
      branch_to(d + 16'h0400, 1'b0);
      for (int i = 0; i < 6; i++) take_bytes(1'b0);
      @(negedge clk_i);
      bus.prefetch_en = 1'b1;
      req.take = 1'b0;
      branch_to(d + 16'h0200, 1'b0);
      for (int i = 0; i < 6; i++) take_bytes(1'($random(seed)));
      @(negedge clk_i);
      req.take = 1'b0;
      chk(notes.size() == 0, "notes left over");
    end
    summarize();
  end
endmodule : tb_cpbc_prefetch
